// ===== dcp_top.v
// dual compare pulse generator channel with apb register access
// assumes an apb master on REF_CLK_IN and source ticks synchronous to it
`timescale 1ns/1ps
`include "dcp_defines.vh"
module dcp_top (
	// clock and reset
	input  wire        REF_CLK_IN,
	input  wire        RST_N_IN,
	// apb slave
	input  wire        PSEL_IN,
	input  wire        PENABLE_IN,
	input  wire        PWRITE_IN,
	input  wire [31:0] PADDR_IN,
	input  wire [31:0] PWDATA_IN,
	output reg  [31:0] PRDATA_OUT,
	output reg         PREADY_OUT,
	output reg         PSLVERR_OUT,
	// timer sources
	input  wire [4:0]  TICK_SRC_IN,
	input  wire [31:0] SYNC_SRC_IN,
	input  wire        GT1_SYNC_IN,
	input  wire        GT1_RUN_IN,
	// channel outputs
	output reg         COMPARE_PIN_OUT,
	output reg         IRQ_FLAG_OUT
);

	// registers
	reg  [2:0]  mode_q;
	reg  [2:0]  clk_sel_q;
	reg  [4:0]  sync_sel_q;
	reg  [15:0] first_q;
	reg  [15:0] second_q;
	reg  [15:0] timer_q;
	reg         flag_q;
	reg         done_q;
	reg         fresh_q;
	reg         sync_pend_q;
	reg         start_q;

	// bus decode
	wire        access;
	wire        wr_en;
	wire        rd_en;
	wire [4:0]  addr;
	wire        mapped;
	wire [2:0]  wr_mode;
	reg  [31:0] rd_word;

	// source selection results
	wire        tick_sel;
	wire        ext_sync;
	wire        src_run;

	// compare terms
	wire        active;
	wire        tick;
	wire        both_zero;
	wire        hit_first;
	wire        hit_second;
	wire        self_sync;
	wire        sync_now;
	wire        rise;
	wire        fall;
	wire        flag_clr;

	dcp_src_sel i_dcp_src_sel (
		.clk_sel_in   (clk_sel_q),
		.sync_sel_in  (sync_sel_q),
		.tick_src_in  (TICK_SRC_IN),
		.sync_src_in  (SYNC_SRC_IN),
		.gt1_sync_in  (GT1_SYNC_IN),
		.gt1_run_in   (GT1_RUN_IN),
		.tick_out     (tick_sel),
		.ext_sync_out (ext_sync),
		.run_out      (src_run)
	);

	// one wait state: ready rises in the second access cycle, transfer completes there
	assign access  = PSEL_IN & PENABLE_IN & PREADY_OUT;
	assign wr_en   = access & PWRITE_IN;
	assign rd_en   = PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN;
	assign addr    = PADDR_IN[4:0];
	assign wr_mode = PWDATA_IN[`DCP_MODE_MSB:`DCP_MODE_LSB];
	assign mapped  = (PADDR_IN[31:5] == 27'h0000000) &&
		((addr == `DCP_OFS_CTRL) || (addr == `DCP_OFS_FIRST) ||
		(addr == `DCP_OFS_SECOND) || (addr == `DCP_OFS_TIMER) ||
		(addr == `DCP_OFS_STATUS));

	always @* begin
		rd_word = `DCP_WORD_ZERO;
		case (addr)
			`DCP_OFS_CTRL: begin
				rd_word[`DCP_MODE_MSB:`DCP_MODE_LSB] = mode_q;
				rd_word[`DCP_CLK_MSB:`DCP_CLK_LSB]   = clk_sel_q;
				rd_word[`DCP_SYNC_MSB:`DCP_SYNC_LSB] = sync_sel_q;
			end
			`DCP_OFS_FIRST: begin
				rd_word[15:0] = first_q;
			end
			`DCP_OFS_SECOND: begin
				rd_word[15:0] = second_q;
			end
			`DCP_OFS_TIMER: begin
				rd_word[15:0] = timer_q;
			end
			`DCP_OFS_STATUS: begin
				rd_word[`DCP_ST_FLAG] = flag_q;
				rd_word[`DCP_ST_PIN]  = COMPARE_PIN_OUT;
				rd_word[`DCP_ST_DONE] = done_q;
			end
			default: begin
				rd_word = `DCP_WORD_ZERO;
			end
		endcase
	end

	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			PREADY_OUT  <= 1'b0;
			PRDATA_OUT  <= `DCP_WORD_ZERO;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT  <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
			PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
			if (rd_en)
				PRDATA_OUT <= rd_word;
		end
	end

	// control registers and start request
	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			mode_q     <= `DCP_MODE_OFF;
			clk_sel_q  <= 3'h0;
			sync_sel_q <= 5'h00;
			first_q    <= `DCP_CNT_ZERO;
			second_q   <= `DCP_CNT_ZERO;
			start_q    <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (wr_en && (addr == `DCP_OFS_CTRL)) begin
				mode_q     <= wr_mode;
				clk_sel_q  <= PWDATA_IN[`DCP_CLK_MSB:`DCP_CLK_LSB];
				sync_sel_q <= PWDATA_IN[`DCP_SYNC_MSB:`DCP_SYNC_LSB];
				// a repeat write of the single code restarts; continuous keeps running
				if (wr_mode == `DCP_MODE_SINGLE)
					start_q <= 1'b1;
				else if ((wr_mode == `DCP_MODE_CONT) && (mode_q != `DCP_MODE_CONT))
					start_q <= 1'b1;
			end
			if (wr_en && (addr == `DCP_OFS_FIRST))
				first_q <= PWDATA_IN[15:0];
			if (wr_en && (addr == `DCP_OFS_SECOND))
				second_q <= PWDATA_IN[15:0];
		end
	end

	// only dual compare codes run this channel; other codes leave it idle
	assign active     = (mode_q == `DCP_MODE_SINGLE) || (mode_q == `DCP_MODE_CONT);
	assign tick       = active & tick_sel & src_run & ~start_q;
	assign both_zero  = (first_q == `DCP_CNT_ZERO) && (second_q == `DCP_CNT_ZERO);
	// a zero first value is not taken on the very first count after enable
	assign hit_first  = (timer_q == first_q) & ~both_zero &
		~(fresh_q & (timer_q == `DCP_CNT_ZERO));
	assign hit_second = (timer_q == second_q) & ~both_zero;
	assign self_sync  = (sync_sel_q == `DCP_SYNC_SELF) && (timer_q == second_q);
	assign sync_now   = sync_pend_q | ext_sync | self_sync;
	assign rise       = tick & ~done_q & ~COMPARE_PIN_OUT & hit_first;
	assign fall       = tick & ~done_q & COMPARE_PIN_OUT & hit_second;
	assign flag_clr   = wr_en && (addr == `DCP_OFS_STATUS) && PWDATA_IN[`DCP_ST_FLAG];

	// channel timer and sync handling
	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			timer_q     <= `DCP_CNT_ZERO;
			fresh_q     <= 1'b0;
			sync_pend_q <= 1'b0;
		end else if (start_q || !active) begin
			timer_q     <= `DCP_CNT_ZERO;
			fresh_q     <= 1'b1;
			sync_pend_q <= 1'b0;
		end else if (tick) begin
			fresh_q     <= 1'b0;
			sync_pend_q <= 1'b0;
			if (sync_now)
				timer_q <= `DCP_CNT_ZERO;
			else
				timer_q <= timer_q + `DCP_CNT_ONE;
		end else if (ext_sync) begin
			// a sync between slow ticks is held until the next timer clock
			sync_pend_q <= 1'b1;
		end
	end

	// output pin, single pulse completion and interrupt flag
	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			COMPARE_PIN_OUT <= 1'b0;
			done_q          <= 1'b0;
			flag_q          <= 1'b0;
			IRQ_FLAG_OUT    <= 1'b0;
		end else begin
			if (start_q || !active) begin
				COMPARE_PIN_OUT <= 1'b0;
				done_q          <= 1'b0;
			end else if (rise) begin
				COMPARE_PIN_OUT <= 1'b1;
			end else if (fall) begin
				COMPARE_PIN_OUT <= 1'b0;
				if (mode_q == `DCP_MODE_SINGLE)
					done_q <= 1'b1;
			end
			// set wins over a clear in the same cycle
			if (fall)
				flag_q <= 1'b1;
			else if (flag_clr)
				flag_q <= 1'b0;
			IRQ_FLAG_OUT <= fall | (flag_q & ~flag_clr);
		end
	end

endmodule

// ===== dcp_defines.vh
// constants for the dual compare pulse generator: register map, fields, codes
// assumes a 32-bit apb master and one 200 MHz reference clock
//
// Functional notes
// - mode code 5 drives pin low at enable, then repeats pulses
// - first match of timer with first compare value drives pin high
// - later match with second compare value drives pin low, sets irq flag
// - continuous mode pulses until mode change or reset; every fall sets flag
// - sync at timer equal second value: timer zero next cycle, pulse intact
// - sync before first match: timer to zero, pin stays low
// - sync between first and second match: only rising edge that cycle
// - both compare values zero: pin stays low, no interrupt
// - second below first: rise, restart from zero, then fall with interrupt
// - equal values: rise at match, fall and interrupt at next match after restart
// - first zero, second larger: low first cycle, high after reset, fall at second
// - odd sequences repeat in continuous mode, happen once in single mode
// - writing mode code 4 selects single pulse and starts it at once
// - timer holds while selected external sync timer is off
// - clock select value 7 routes peripheral clock to channel timer
// - sync select 0x0B makes general timer one the sync source
// - with self sync the period is the second compare value plus one timer clocks
// - rewriting single pulse code after the pulse starts a new pulse
// - mode code zero disables the channel
`ifndef DCP_DEFINES_VH
`define DCP_DEFINES_VH

`define DCP_ADDR_W      5
`define DCP_OFS_CTRL    5'h00
`define DCP_OFS_FIRST   5'h04
`define DCP_OFS_SECOND  5'h08
`define DCP_OFS_TIMER   5'h0C
`define DCP_OFS_STATUS  5'h10

`define DCP_MODE_LSB    0
`define DCP_MODE_MSB    2
`define DCP_CLK_LSB     10
`define DCP_CLK_MSB     12
`define DCP_SYNC_LSB    16
`define DCP_SYNC_MSB    20
`define DCP_ST_FLAG     0
`define DCP_ST_PIN      1
`define DCP_ST_DONE     2

`define DCP_MODE_OFF    3'h0
`define DCP_MODE_SINGLE 3'h4
`define DCP_MODE_CONT   3'h5

`define DCP_CLK_PERIPH  3'h7
`define DCP_SYNC_NONE   5'h00
`define DCP_SYNC_GENERAL_TIMER_ONE   5'h0B
`define DCP_SYNC_SELF   5'h1F

`define DCP_CNT_ZERO    16'h0000
`define DCP_CNT_ONE     16'h0001
`define DCP_WORD_ZERO   32'h0000_0000

`endif

// ===== dcp_src_sel.v
// clock and sync source selection for the channel timer
// assumes source ticks, sync pulses and run levels are synchronous to the clock
`timescale 1ns/1ps
`include "dcp_defines.vh"
module dcp_src_sel (
	// selects
	input  wire [2:0]  clk_sel_in,
	input  wire [4:0]  sync_sel_in,
	// timer clock sources, codes 0 to 4
	input  wire [4:0]  tick_src_in,
	// other sync sources, indexed by select code
	input  wire [31:0] sync_src_in,
	// general timer one
	input  wire        gt1_sync_in,
	input  wire        gt1_run_in,
	// results
	output reg         tick_out,
	output reg         ext_sync_out,
	output reg         run_out
);

	always @* begin
		if (clk_sel_in == `DCP_CLK_PERIPH)
			tick_out = 1'b1;
		else if (clk_sel_in < 3'h5)
			tick_out = tick_src_in[clk_sel_in];
		else
			tick_out = 1'b0;
	end

	// self sync is decided by the compare logic, so it is not an external event here
	always @* begin
		ext_sync_out = 1'b0;
		run_out      = 1'b1;
		case (sync_sel_in)
			`DCP_SYNC_NONE: begin
				ext_sync_out = 1'b0;
			end
			`DCP_SYNC_SELF: begin
				ext_sync_out = 1'b0;
			end
			`DCP_SYNC_GENERAL_TIMER_ONE: begin
				ext_sync_out = gt1_sync_in;
				run_out      = gt1_run_in;
			end
			default: begin
				ext_sync_out = sync_src_in[sync_sel_in];
			end
		endcase
	end

endmodule

// ===== dcp_top_asserts.sv
// port checker for the dual compare pulse channel
// assumes one clock domain and an apb master that holds each request
`timescale 1ns/1ps
module dcp_chk (
	// clock and reset
	input wire logic        REF_CLK_IN,
	input wire logic        RST_N_IN,
	// apb slave
	input wire logic        PSEL_IN, PENABLE_IN, PWRITE_IN,
	input wire logic [31:0] PADDR_IN, PWDATA_IN, PRDATA_OUT,
	input wire logic        PREADY_OUT, PSLVERR_OUT,
	// timer sources
	input wire logic [4:0]  TICK_SRC_IN,
	input wire logic [31:0] SYNC_SRC_IN,
	input wire logic        GT1_SYNC_IN, GT1_RUN_IN,
	// channel outputs
	input wire logic        COMPARE_PIN_OUT, IRQ_FLAG_OUT
);
	logic [2:0] mode_q;
	wire        wr_c = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// mode is tracked from the bus so that forced falls on disable are excused
	always @(posedge REF_CLK_IN) begin
		if (!RST_N_IN)
			mode_q <= 3'h0;
		else if (wr_c && PADDR_IN == 32'h0)
			mode_q <= PWDATA_IN[2:0];
	end
	property p_wait; PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT; endproperty
	property p_one; PREADY_OUT |=> !PREADY_OUT; endproperty
	property p_err; PREADY_OUT |->
		PSLVERR_OUT == !(PADDR_IN inside {32'h0, 32'h4, 32'h8, 32'hC, 32'h10}); endproperty
	property p_rd0; PREADY_OUT && PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0; endproperty
	property p_fall; $fell(COMPARE_PIN_OUT) && mode_q[2] && !mode_q[1]
		&& !$past(wr_c) && !$past(wr_c, 2) |-> IRQ_FLAG_OUT; endproperty
	property p_stick; IRQ_FLAG_OUT && !(wr_c && PADDR_IN == 32'h10 && PWDATA_IN[0])
		|=> IRQ_FLAG_OUT; endproperty
	property p_rise; $rose(IRQ_FLAG_OUT) |-> $fell(COMPARE_PIN_OUT); endproperty
	property p_off; mode_q != 3'h4 && mode_q != 3'h5 |=> !COMPARE_PIN_OUT; endproperty
	property p_start; wr_c && PADDR_IN == 32'h0 && PWDATA_IN[2:0] == 3'h4
		|=> ##1 !COMPARE_PIN_OUT; endproperty
	a_wait: assert property (p_wait) else $error("ready not one cycle after access");
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	a_err: assert property (p_err) else $error("slave error does not match address");
	a_rd0: assert property (p_rd0) else $error("unmapped read data not zero");
	a_fall: assert property (p_fall) else $error("pulse end without flag");
	a_stick: assert property (p_stick) else $error("flag dropped");
	a_rise: assert property (p_rise) else $error("flag set without falling pin");
	a_off: assert property (p_off) else $error("pin high while idle");
	a_start: assert property (p_start) else $error("pin not low at start");
	c_pin: cover property ($rose(COMPARE_PIN_OUT));
	c_irq: cover property ($rose(IRQ_FLAG_OUT));
	c_err: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule
bind dcp_top dcp_chk i_dcp_chk (.*);

// ===== dcp_load.sv
// load on the compare pin: reports each level change and its length
// assumes the pin is a registered level on the bench clock
`timescale 1ns/1ps
module dcp_load (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// compare pin
	input  wire logic        pin_in,
	// edge report, one cycle after the edge
	output logic             ev_out,
	output logic             lvl_out,
	output logic [15:0]      len_out
);
	logic        pin_q = 1'b0;
	logic [15:0] cnt_q = 16'h0;
	always @(posedge clk_in) begin
		ev_out <= rst_n_in && pin_in !== pin_q;
		lvl_out <= pin_in;
		len_out <= cnt_q;
		cnt_q <= (pin_in !== pin_q) ? 16'h1 : cnt_q + 16'h1;
		pin_q <= pin_in;
	end
endmodule

// ===== test_dual_compare_pulse_generator.sv
// self-checking bench: apb stimulus, expected pin edges and reads in queues
// assumes dcp_top, dcp_chk and dcp_load are compiled first
`timescale 1ns/1ps
module test_dual_compare_pulse_generator;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, ssrc = 32'h0;
	logic [4:0]  tick = 5'h0;
	logic        gsync = 1'b0, grun = 1'b0, gt_on = 1'b0;
	logic [3:0]  gcnt = 4'h0;
	logic [32:0] rq[$];
	logic [16:0] pq[$];
	logic [16:0] pe;
	logic [15:0] f, s;
	integer      n_errors = 0, comparisons = 0, seed = 99487;
	wire  [31:0] prdata;
	wire  [15:0] len;
	wire         pready, pslverr, pin, irq, ev, lvl;
	dcp_top i_dcp_top (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TICK_SRC_IN(tick), .SYNC_SRC_IN(ssrc),
		.GT1_SYNC_IN(gsync), .GT1_RUN_IN(grun), .COMPARE_PIN_OUT(pin), .IRQ_FLAG_OUT(irq));
	dcp_load i_dcp_load (.clk_in(clk), .rst_n_in(rst_n), .pin_in(pin), .ev_out(ev),
		.lvl_out(lvl), .len_out(len));
	always #2.5 clk = ~clk;
	// unselected sources toggle at random; timer one syncs every ten cycles
	always @(posedge clk) begin
		ssrc <= $random(seed);
		tick <= ssrc[4:0];
		gcnt <= (gcnt == 4'h9) ? 4'h0 : gcnt + 4'h1;
		gsync <= gt_on && gcnt == 4'h9;
		grun <= gt_on;
	end
	task chk(input logic [32:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("comparisons %0d, n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task bus(input logic w, input logic [31:0] a, d);
		integer i;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; pready !== 1'b1; i++) begin
			@(posedge clk);
			if (i > 20) begin
				n_errors++;
				close_out;
			end
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [31:0] a, d); bus(1'b1, a, d); endtask
	task rd(input logic [31:0] a, input logic [32:0] e); rq.push_back(e); bus(1'b0, a, 32'h0); endtask
	task ex(input logic l, input logic [15:0] w); pq.push_back({l, w}); endtask
	// width zero in a note means the length of that level is not judged
	task pat(input logic [15:0] hw, lw, input integer n);
		ex(1'b1, 16'h0);
		ex(1'b0, hw);
		repeat (n - 1) begin
			ex(1'b1, lw);
			ex(1'b0, hw);
		end
	endtask
	task drain(input integer n);
		integer i;
		for (i = 0; pq.size() > n; i++) begin
			@(posedge clk);
			if (i > 3000) begin
				n_errors++;
				close_out;
			end
		end
	endtask
	function automatic logic [31:0] cfg(input logic [4:0] sel, input logic [2:0] m);
		return {11'h0, sel, 3'h0, 3'h7, 7'h0, m};
	endfunction
	task go(input logic [15:0] a, b, input logic [4:0] sel, input logic [2:0] m);
		wr(32'h0, 32'h0);
		wr(32'h10, 32'h1);
		wr(32'h4, {16'h0, a});
		wr(32'h8, {16'h0, b});
		wr(32'h0, cfg(sel, m));
	endtask
	always @(posedge clk) begin
		if (psel && pen && pready && !pwr)
			chk({pslverr, prdata}, rq.pop_front());
		if (ev) begin
			pe = pq.size() ? pq.pop_front() : 17'h1FFFF;
			chk({lvl, pe[15:0] == 16'h0 ? 16'h0 : len}, pe);
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 6; k++)
			rd(k < 5 ? 4 * k : 32'h40, {k == 5, 32'h0});
		$display("done: reset values and unmapped read");
		f = 16'h8 + ($random(seed) & 16'h7);
		s = f + 16'h2 + ($random(seed) & 16'hF);
		pat(s - f, f + 16'h1, 3);
		go(f, s, 5'h1F, 3'h5);
		drain(0);
		wr(32'h0, 32'h0);
		repeat (60) @(posedge clk);
		rd(32'h10, 33'h1);
		wr(32'h10, 32'h1);
		rd(32'h10, 33'h0);
		$display("done: continuous pulses");
		pat(16'h4, 16'h0, 1);
		go(16'h5, 16'h9, 5'h1F, 3'h4);
		drain(0);
		repeat (80) @(posedge clk);
		rd(32'h10, 33'h5);
		pat(16'h4, 16'h0, 1);
		wr(32'h0, cfg(5'h1F, 3'h4));
		drain(0);
		$display("done: single pulse");
		pat(16'hD, 16'hD, 2);
		go(16'hC, 16'hC, 5'h1F, 3'h5);
		drain(0);
		pat(16'hA, 16'h1, 2);
		ex(1'b1, 16'h1);
		ex(1'b0, 16'h0);
		go(16'h0, 16'hA, 5'h1F, 3'h5);
		drain(1);
		wr(32'h0, 32'h0);
		drain(0);
		go(16'h0, 16'h0, 5'h1F, 3'h5);
		repeat (100) @(posedge clk);
		rd(32'h10, 33'h0);
		$display("done: unusual compare values");
		go(16'h5, 16'h1E, 5'h0B, 3'h5);
		repeat (40) @(posedge clk);
		rd(32'hC, 33'h0);
		ex(1'b1, 16'h0);
		gt_on <= 1'b1;
		drain(0);
		repeat (100) @(posedge clk);
		ex(1'b0, 16'h0);
		wr(32'h0, 32'h0);
		drain(0);
		ex(1'b1, 16'h0);
		ex(1'b0, 16'h0);
		ex(1'b1, 16'h3);
		ex(1'b0, 16'h7);
		ex(1'b1, 16'h3);
		ex(1'b0, 16'h0);
		go(16'h5, 16'h2, 5'h0B, 3'h5);
		drain(1);
		wr(32'h0, 32'h0);
		drain(0);
		rd(32'h10, 33'h1);
		go(16'h14, 16'h1E, 5'h0B, 3'h5);
		repeat (100) @(posedge clk);
		rd(32'h10, 33'h0);
		$display("done: timer one sync");
		close_out;
	end
endmodule
